// [rtl/hcs_pkg.sv]
// Constants, register map and types for the high carrier select block
package hcs_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_HIGH_CTRL = 12'h000;
  localparam logic [11:0] ADDR_LOW_CTRL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PIN_DIS_BIT = 7;
  localparam int INVERT_BIT = 6;
  localparam int SYNC_BIT = 5;
  localparam int SEL_MSB = 3;
  localparam int ST_USE_HIGH_BIT = 0;
  localparam int ST_HIGH_LVL_BIT = 1;
  localparam int ST_PENDING_BIT = 2;
  localparam int ST_ABSENT_BIT = 3;

  // ----------------------------------------------------------------
  // Reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [7:0] HIGH_CTRL_RST = 8'h00;
  localparam logic [7:0] HIGH_CTRL_MASK = 8'hEF;
  localparam logic [7:0] LOW_CTRL_RST = 8'h00;
  localparam logic [7:0] LOW_CTRL_MASK = 8'h20;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carrier selector codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_CONST_LOW = 4'h0;
  localparam logic [3:0] SEL_PIN_ONE = 4'h1;
  localparam logic [3:0] SEL_PIN_TWO = 4'h2;
  localparam logic [3:0] SEL_REF_CLK = 4'h3;
  localparam logic [3:0] SEL_CCP_PWM = 4'h4;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RS_HIGH,
    RS_LOW,
    RS_STATUS,
    RS_NONE
  } reg_sel_e;

  typedef enum logic [1:0] {
    ST_LOW,
    ST_TO_HIGH,
    ST_HIGH,
    ST_TO_LOW
  } mix_state_e;

endpackage

// [rtl/high_carrier_select.sv]
// High carrier selection, conditioning and synchronised mixing stage
`timescale 1ns/1ps

module high_carrier_select (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic SRST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Carrier sources
  input wire logic CARRIER_INPUT_PIN_ONE,
  input wire logic CARRIER_INPUT_PIN_TWO,
  input wire logic REFERENCE_CLOCK_OUTPUT,
  input wire logic CAPTURE_COMPARE_PWM,
  // Modulator side
  input wire logic MOD_SOURCE,
  input wire logic LOW_CARRIER,
  output logic HIGH_CARRIER,
  output logic MOD_OUT,
  // Carrier pin drive
  output logic HIGH_CARRIER_PIN_O,
  output logic HIGH_CARRIER_PIN_OE
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic hcs_pkg::reg_sel_e reg_decode(
    input logic [11:0] addr
  );
    reg_decode = hcs_pkg::RS_NONE;
    case (addr)
      hcs_pkg::ADDR_HIGH_CTRL: begin
        reg_decode = hcs_pkg::RS_HIGH;
      end
      hcs_pkg::ADDR_LOW_CTRL: begin
        reg_decode = hcs_pkg::RS_LOW;
      end
      hcs_pkg::ADDR_STATUS: begin
        reg_decode = hcs_pkg::RS_STATUS;
      end
      default: begin
        reg_decode = hcs_pkg::RS_NONE;
      end
    endcase
  endfunction

  function automatic logic code_connected(input logic [3:0] code);
    code_connected = (code <= hcs_pkg::SEL_CCP_PWM);
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] high_ctrl_ff;
  logic [7:0] low_ctrl_ff;
  logic [31:0] prdata_ff;
  hcs_pkg::reg_sel_e sel_now;
  logic wr_en;
  logic setup;
  logic [3:0] sel_code;
  logic pin_dis;
  logic invert;
  logic high_sync;
  logic low_sync;
  logic carrier_raw;
  logic carrier_absent;
  logic carrier_cond;
  logic [1:0] carr_vec;
  logic [1:0] prev_ff;
  logic [1:0] fall;
  logic high_fall;
  logic low_fall;
  hcs_pkg::mix_state_e state_ff;
  hcs_pkg::mix_state_e nxt_state;
  logic nxt_use_high;
  logic mod_out_ff;
  logic high_carrier_ff;
  logic pin_o_ff;
  logic pin_oe_ff;
  logic [31:0] status_word;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign sel_now = reg_decode(PADDR);
  assign setup = PSEL & ~PENABLE;
  assign wr_en = PSEL & PENABLE & PWRITE;
  assign PREADY = PSEL & PENABLE;
  assign PSLVERR = PSEL & PENABLE & (sel_now == hcs_pkg::RS_NONE);
  assign PRDATA = prdata_ff;

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      high_ctrl_ff <= hcs_pkg::HIGH_CTRL_RST;
    end else if (wr_en && sel_now == hcs_pkg::RS_HIGH) begin
      high_ctrl_ff <= PWDATA[7:0] & hcs_pkg::HIGH_CTRL_MASK;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      low_ctrl_ff <= hcs_pkg::LOW_CTRL_RST;
    end else if (wr_en && sel_now == hcs_pkg::RS_LOW) begin
      low_ctrl_ff <= PWDATA[7:0] & hcs_pkg::LOW_CTRL_MASK;
    end
  end

  // Read data is captured in the setup cycle, so it is a flop output
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      prdata_ff <= hcs_pkg::RDATA_RST;
    end else if (setup && !PWRITE) begin
      case (sel_now)
        hcs_pkg::RS_HIGH: begin
          prdata_ff <= {24'h00_0000, high_ctrl_ff};
        end
        hcs_pkg::RS_LOW: begin
          prdata_ff <= {24'h00_0000, low_ctrl_ff};
        end
        hcs_pkg::RS_STATUS: begin
          prdata_ff <= status_word;
        end
        default: begin
          prdata_ff <= hcs_pkg::RDATA_RST;
        end
      endcase
    end
  end

  always_comb begin
    status_word = hcs_pkg::RDATA_RST;
    status_word[hcs_pkg::ST_USE_HIGH_BIT] =
      (state_ff == hcs_pkg::ST_HIGH) || (state_ff == hcs_pkg::ST_TO_LOW);
    status_word[hcs_pkg::ST_HIGH_LVL_BIT] = high_carrier_ff;
    status_word[hcs_pkg::ST_PENDING_BIT] =
      (state_ff == hcs_pkg::ST_TO_HIGH) || (state_ff == hcs_pkg::ST_TO_LOW);
    status_word[hcs_pkg::ST_ABSENT_BIT] = carrier_absent;
  end

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  assign sel_code = high_ctrl_ff[hcs_pkg::SEL_MSB:0];
  assign pin_dis = high_ctrl_ff[hcs_pkg::PIN_DIS_BIT];
  assign invert = high_ctrl_ff[hcs_pkg::INVERT_BIT];
  assign high_sync = high_ctrl_ff[hcs_pkg::SYNC_BIT];
  assign low_sync = low_ctrl_ff[hcs_pkg::SYNC_BIT];

  // ----------------------------------------------------------------
  // Carrier selection and polarity
  // ----------------------------------------------------------------
  always_comb begin
    carrier_raw = 1'b0;
    case (sel_code)
      hcs_pkg::SEL_CONST_LOW: begin
        carrier_raw = 1'b0;
      end
      hcs_pkg::SEL_PIN_ONE: begin
        carrier_raw = CARRIER_INPUT_PIN_ONE;
      end
      hcs_pkg::SEL_PIN_TWO: begin
        carrier_raw = CARRIER_INPUT_PIN_TWO;
      end
      hcs_pkg::SEL_REF_CLK: begin
        carrier_raw = REFERENCE_CLOCK_OUTPUT;
      end
      hcs_pkg::SEL_CCP_PWM: begin
        carrier_raw = CAPTURE_COMPARE_PWM;
      end
      default: begin
        carrier_raw = 1'b0;
      end
    endcase
  end

  assign carrier_absent = ~code_connected(sel_code);
  assign carrier_cond = carrier_absent ? 1'b0 : (carrier_raw ^ invert);

  // ----------------------------------------------------------------
  // Falling edge detection on both carriers
  // ----------------------------------------------------------------
  assign carr_vec = {LOW_CARRIER, carrier_cond};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_edge
      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          prev_ff[gi] <= 1'b0;
        end else begin
          prev_ff[gi] <= carr_vec[gi];
        end
      end
      assign fall[gi] = prev_ff[gi] & ~carr_vec[gi];
    end
  endgenerate

  assign high_fall = fall[0];
  assign low_fall = fall[1];

  // ----------------------------------------------------------------
  // Switching state machine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      hcs_pkg::ST_LOW: begin
        if (MOD_SOURCE) begin
          nxt_state = low_sync ? hcs_pkg::ST_TO_HIGH : hcs_pkg::ST_HIGH;
        end
      end
      hcs_pkg::ST_TO_HIGH: begin
        if (!MOD_SOURCE) begin
          nxt_state = hcs_pkg::ST_LOW;
        end else if (low_fall || !low_sync) begin
          // Low edge completes switch
          // Clearing low sync while pending must not strand the switch
          nxt_state = hcs_pkg::ST_HIGH;
        end
      end
      hcs_pkg::ST_HIGH: begin
        if (!MOD_SOURCE) begin
          nxt_state = high_sync ? hcs_pkg::ST_TO_LOW : hcs_pkg::ST_LOW;
        end
      end
      hcs_pkg::ST_TO_LOW: begin
        if (MOD_SOURCE) begin
          nxt_state = hcs_pkg::ST_HIGH;
        end else if (high_fall || !high_sync) begin
          nxt_state = hcs_pkg::ST_LOW;
        end
      end
      default: begin
        nxt_state = hcs_pkg::ST_LOW;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_ff <= hcs_pkg::ST_LOW;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pending states keep the carrier already in use, avoiding spurs
  assign nxt_use_high = (nxt_state == hcs_pkg::ST_HIGH) ||
                        (nxt_state == hcs_pkg::ST_TO_LOW);

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      mod_out_ff <= 1'b0;
    end else begin
      mod_out_ff <= nxt_use_high ? carrier_cond : LOW_CARRIER;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      high_carrier_ff <= 1'b0;
    end else begin
      high_carrier_ff <= carrier_cond;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      pin_o_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      pin_o_ff <= pin_dis ? 1'b0 : carrier_raw;
      pin_oe_ff <= ~pin_dis & ~carrier_absent;
    end
  end

  assign MOD_OUT = mod_out_ff;
  assign HIGH_CARRIER = high_carrier_ff;
  assign HIGH_CARRIER_PIN_O = pin_o_ff;
  assign HIGH_CARRIER_PIN_OE = pin_oe_ff;

endmodule

// [verif/carrier_sources.sv]
// Model of the carrier sources and carrier input pins
`timescale 1ns/1ps
module carrier_sources (
  // Clock and control
  input wire logic clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [3:0] hold,
  // Pin one, pin two, reference clock, capture PWM
  output logic [3:0] src
);
  logic [4:0] cnt_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= 5'h00;
    end else begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end
  // Distinct rates, so a wrong selection shows
  assign src = run ? {cnt_ff[3], cnt_ff[0], cnt_ff[1] ^ cnt_ff[3],
    cnt_ff[2]} : hold;
endmodule

// [verif/high_carrier_select_assertions.sv]
// Assertions for the high carrier select block
`timescale 1ns/1ps
module hcs_checker (
  // Clock, reset, APB
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Carriers and modulator
  input wire logic CARRIER_INPUT_PIN_ONE,
  input wire logic CARRIER_INPUT_PIN_TWO,
  input wire logic REFERENCE_CLOCK_OUTPUT,
  input wire logic CAPTURE_COMPARE_PWM,
  input wire logic MOD_SOURCE,
  input wire logic LOW_CARRIER,
  input wire logic HIGH_CARRIER,
  input wire logic MOD_OUT,
  input wire logic HIGH_CARRIER_PIN_O,
  input wire logic HIGH_CARRIER_PIN_OE
);
  logic [7:0] hc_ff;
  logic ls_ff;
  logic raw;
  logic ok;
  logic wr;
  assign wr = PSEL && PENABLE && PWRITE;
  assign ok = hc_ff[3:0] < 4'h5;
  // Shadow control bits, taken when the slave takes them
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      hc_ff <= 8'h00;
      ls_ff <= 1'b0;
    end else if (wr && PADDR == hcs_pkg::ADDR_HIGH_CTRL) begin
      hc_ff <= PWDATA[7:0] & hcs_pkg::HIGH_CTRL_MASK;
    end else if (wr && PADDR == hcs_pkg::ADDR_LOW_CTRL) begin
      ls_ff <= PWDATA[5];
    end
  end
  always_comb begin
    case (hc_ff[3:0])
      4'h1: raw = CARRIER_INPUT_PIN_ONE;
      4'h2: raw = CARRIER_INPUT_PIN_TWO;
      4'h3: raw = REFERENCE_CLOCK_OUTPUT;
      4'h4: raw = CAPTURE_COMPARE_PWM;
      default: raw = 1'b0;
    endcase
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  a_pin_disable: assert property ($past(hc_ff[7]) |->
    !HIGH_CARRIER_PIN_OE && !HIGH_CARRIER_PIN_O) else $error("pin on");
  a_carrier_invert: assert property (
    HIGH_CARRIER == $past(ok && (raw ^ hc_ff[6]))) else $error("carrier");
  a_high_sync_done: assert property ((!MOD_SOURCE)[*3] ##0
    $fell(HIGH_CARRIER) ##1 (!MOD_SOURCE && $stable(LOW_CARRIER))[*2]
    |-> MOD_OUT == LOW_CARRIER) else $error("high sync");
  a_nosync_switch: assert property ((!hc_ff[5] && !ls_ff && MOD_SOURCE
    && $stable(HIGH_CARRIER))[*3] |-> MOD_OUT == HIGH_CARRIER)
    else $error("no sync");
  a_absent_code: assert property ($past(!ok) |->
    !HIGH_CARRIER && !HIGH_CARRIER_PIN_OE) else $error("absent");
  a_pin_raw: assert property ($past(!hc_ff[7] && ok && raw) |->
    HIGH_CARRIER_PIN_OE && HIGH_CARRIER_PIN_O) else $error("pin raw");
  a_low_sync_done: assert property (MOD_SOURCE[*3] ##0
    $fell(LOW_CARRIER) ##1 (MOD_SOURCE && $stable(HIGH_CARRIER))[*2]
    |-> MOD_OUT == HIGH_CARRIER) else $error("low sync");
  a_apb_answer: assert property (PREADY == (PSEL && PENABLE) &&
    PSLVERR == (PREADY && PADDR != hcs_pkg::ADDR_HIGH_CTRL &&
    PADDR != hcs_pkg::ADDR_LOW_CTRL && PADDR != hcs_pkg::ADDR_STATUS))
    else $error("apb");
  c_high_fall: cover property (hc_ff[5] && $fell(HIGH_CARRIER));
  c_low_fall: cover property (ls_ff && $fell(LOW_CARRIER));
  c_slverr: cover property (PSLVERR);
endmodule
bind high_carrier_select hcs_checker chk_inst (.*);

// [verif/high_carrier_select_tb_top.sv]
// Testbench for the high carrier select block
`timescale 1ns/1ps
module high_carrier_select_tb_top;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, serr;
  logic mod_source, low_carrier, run, hc, mo, po, poe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] hold, src;
  int num_errors, n_tests;
  high_carrier_select high_carrier_select_inst (.CORE_CLK(clk),
    .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CARRIER_INPUT_PIN_ONE(src[0]),
    .CARRIER_INPUT_PIN_TWO(src[1]), .REFERENCE_CLOCK_OUTPUT(src[2]),
    .CAPTURE_COMPARE_PWM(src[3]), .MOD_SOURCE(mod_source),
    .LOW_CARRIER(low_carrier), .HIGH_CARRIER(hc), .MOD_OUT(mo),
    .HIGH_CARRIER_PIN_O(po), .HIGH_CARRIER_PIN_OE(poe));
  carrier_sources carrier_sources_inst (.clk(clk), .srst(srst),
    .run(run), .hold(hold), .src(src));
  always #12.5 clk = ~clk;
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; waits for the slave, bounded by the watchdog
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_regs();
    apb(0, hcs_pkg::ADDR_HIGH_CTRL, 32'h0000_0000);
    chk("ctrl reset", 32'h0000_0000, rd);
    apb(1, hcs_pkg::ADDR_HIGH_CTRL, 32'hFFFF_FFFF);
    chk("ctrl slverr", 32'h0000_0000, serr);
    apb(0, hcs_pkg::ADDR_HIGH_CTRL, 32'h0000_0000);
    chk("ctrl mask", 32'h0000_00EF, rd);
    apb(1, hcs_pkg::ADDR_LOW_CTRL, 32'hFFFF_FFFF);
    apb(0, hcs_pkg::ADDR_LOW_CTRL, 32'h0000_0000);
    chk("low mask", 32'h0000_0020, rd);
    // Low sync back off, the no-sync scenarios rely on it
    apb(1, hcs_pkg::ADDR_LOW_CTRL, 32'h0000_0000);
    apb(0, hcs_pkg::ADDR_STATUS, 32'h0000_0000);
    chk("status", 32'h0000_0008, rd);
    apb(1, 12'h00C, 32'h0000_0001);
    chk("slverr", 1'b1, serr);
  endtask
  task automatic t_select();
    logic [4:0] q;
    logic e;
    run <= 1'b1;
    for (int k = 0; k < 48; k++) begin
      apb(1, hcs_pkg::ADDR_HIGH_CTRL, {24'h00_0000, k[5], k[4], 6'(k[3:0])});
      repeat (2) @(posedge clk);
      @(negedge clk);
      q = {src, 1'b0};
      @(negedge clk);
      e = (k[3:0] < 5) && q[k[3:0]];
      chk("carrier", (k[3:0] < 5) && (e ^ k[4]), hc);
      chk("pin enable", (k[3:0] < 5) && !k[5], poe);
      chk("pin data", e && !k[5], po);
    end
  endtask
  // Outputs are looked at on the falling edge, away from their launch
  task automatic t_sync();
    @(posedge clk);
    run <= 1'b0;
    hold <= 4'h1;
    apb(1, hcs_pkg::ADDR_HIGH_CTRL, 32'h0000_0021);
    mod_source <= 1'b1;
    repeat (4) @(posedge clk);
    mod_source <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("hold high", 1'b1, mo);
    @(posedge clk);
    hold <= 4'h0;
    repeat (2) @(posedge clk);
    // Carrier back high: only a finished switch keeps the output low
    hold <= 4'h1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("after fall", 1'b0, mo);
    apb(1, hcs_pkg::ADDR_HIGH_CTRL, 32'h0000_0001);
    mod_source <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("no sync high", 1'b1, mo);
    repeat (3) @(posedge clk);
    mod_source <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("no sync low", 1'b0, mo);
    apb(1, hcs_pkg::ADDR_LOW_CTRL, 32'h0000_0020);
    hold <= 4'h0;
    low_carrier <= 1'b1;
    repeat (3) @(posedge clk);
    mod_source <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("wait low fall", 1'b1, mo);
    @(posedge clk);
    low_carrier <= 1'b0;
    repeat (2) @(posedge clk);
    hold <= 4'h1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("high after fall", 1'b1, mo);
  endtask
  initial begin
    clk = 1'b0;
    srst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {mod_source, low_carrier, run, hold} = '0;
    num_errors = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_regs();
    t_select();
    t_sync();
    print_verdict();
  end
  initial begin
    #50000;
    num_errors++;
    print_verdict();
  end
endmodule
